// ### common/sacr_pkg.sv
// shared constants for the system and auxiliary control register bank
package sacr_pkg;

  // ----------------------------------------------------------------
  // access target selection
  // ----------------------------------------------------------------
  localparam logic TGT_SYSTEM = 1'h0;
  localparam logic TGT_AUX = 1'h1;

  // ----------------------------------------------------------------
  // system control field positions
  // ----------------------------------------------------------------
  localparam int SYS_XLAT_BIT = 0;
  localparam int SYS_ALIGN_BIT = 1;
  localparam int SYS_RR_BIT = 14;
  // fixed read-as-one bits [23:22], [18], [16], [6:3]; all others zero except fields [14], [1], [0]
  localparam logic [31:0] SYS_FIXED_ONES = 32'h00C5_0078;

  // ----------------------------------------------------------------
  // auxiliary control field positions
  // ----------------------------------------------------------------
  localparam int AUX_FW_BIT = 0;
  localparam int AUX_SMP_BIT = 6;
  localparam int AUX_EXCLUSIVE_CACHE_ENABLE_BIT = 7;
  localparam int AUX_ONEWAY_BIT = 8;
  localparam int AUX_PARITY_BIT = 9;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_XLAT = 1'h0;
  localparam logic RST_ALIGN = 1'h0;
  localparam logic RST_RR = 1'h0;
  localparam logic RST_FW = 1'h0;
  localparam logic RST_SMP = 1'h0;
  localparam logic RST_EXCLUSIVE_CACHE_ENABLE = 1'h0;
  localparam logic RST_ONEWAY = 1'h0;
  localparam logic RST_PARITY = 1'h0;

  // ----------------------------------------------------------------
  // pin synchroniser depth and bank count
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 3;
  localparam int NUM_BANKS = 2;
  localparam int BANK_NONSECURE = 0;
  localparam int BANK_SECURE = 1;

endpackage

// ### logic/sacr_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sacr_pin_sync
  import sacr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_in,
  output var logic level_out
);

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] chain_q;
  logic level_q;
  wire stages_agree = (chain_q[1] == chain_q[2]);

  // shift the pin through three flops; stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[SYNC_STAGES-2:0], pin_in};
    end
  end

  // take the new level only when the last two stages match
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_q <= 1'h0;
    end else if (stages_agree) begin
      level_q <= chain_q[2];
    end
  end

  assign level_out = level_q;

endmodule
`default_nettype wire

// ### logic/sacr_coh_policy.sv
// coherency and cache policy controls derived from the auxiliary fields
`timescale 1ns/1ps
`default_nettype none
module sacr_coh_policy
  import sacr_pkg::*;
#(
  parameter int MULTI_CORE = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic smp_en,
  input wire logic fw_en,
  input wire logic exclusive_cache_enable_en,
  input wire logic evict_valid,
  input wire logic evict_wb_cacheable,
  input wire logic evict_l1_allocated,
  output var logic inner_shared_noncacheable,
  output var logic maint_broadcast_send_en,
  output var logic maint_broadcast_accept_en,
  output var logic coherent_request_en,
  output var logic l2_fill_on_evict
);

  // ----------------------------------------------------------------
  // derived enables
  // ----------------------------------------------------------------
  localparam logic MP = (MULTI_CORE != 0);
  logic fill_q;
  wire noncache_d = ~smp_en;
  wire coh_d = MP & smp_en;
  wire bcast_d = coh_d & fw_en;
  wire fill_d = exclusive_cache_enable_en & evict_valid & evict_wb_cacheable & evict_l1_allocated;

  // register the eviction fill pulse so the data output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fill_q <= 1'h0;
    end else begin
      fill_q <= fill_d;
    end
  end

  assign inner_shared_noncacheable = noncache_d;
  assign maint_broadcast_send_en = bcast_d;
  assign maint_broadcast_accept_en = bcast_d;
  assign coherent_request_en = coh_d;
  assign l2_fill_on_evict = fill_q;

endmodule
`default_nettype wire

// ### logic/sacr_ctrl_regs.sv
// system and auxiliary control register bank reached by coprocessor accesses
//
// Overview of operation
// - system bit 1 enables strict alignment fault checks, resets clear
// - system bit 0 turns address translation on, resets clear
// - any user mode access to system control traps as undefined
// - secure privileged system write while lock is high traps undefined
// - non-secure writes to secure-modify-only fields leave them unchanged
// - reads of secure-modify-only fields return the secure copy
// - writes to read-only system fields have no effect
// - auxiliary register: privileged only, one shared copy, secure writes all
// - non-secure aux: read-only unless permit set, then only participation bit
// - participation clear makes inner shareable memory non-cacheable
// - multiprocessor broadcast of maintenance needs participation and broadcast enable
// - accepting peer maintenance needs participation and broadcast enable
// - participating multiprocessor core exchanges coherent write-back requests
// - aux bit 9 enables parity, resets clear, zero without parity hardware
// - aux bit 8 limits allocation to one way, resets zero
// - aux bit 7 selects exclusive caching, resets disabled
// - exclusive mode fills second level only on qualifying first level eviction
// - aux bit 6 shows coherency participation, resets zero
// - aux bit 0 enables broadcast, resets clear, zero on single core
`timescale 1ns/1ps
`default_nettype none
module sacr_ctrl_regs
  import sacr_pkg::*;
#(
  parameter int MULTI_CORE = 1,
  parameter int PARITY_PRESENT = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_target,
  input wire logic acc_user,
  input wire logic acc_secure,
  input wire logic [31:0] acc_wdata,
  input wire logic core_secure,
  input wire logic secure_config_write_lock,
  input wire logic nonsecure_coherency_write_permit,
  input wire logic evict_valid,
  input wire logic evict_wb_cacheable,
  input wire logic evict_l1_allocated,
  output var logic acc_done,
  output var logic acc_undef,
  output var logic [31:0] acc_rdata,
  output var logic translation_en,
  output var logic align_check_en,
  output var logic round_robin_en,
  output var logic parity_check_en,
  output var logic single_way_alloc_en,
  output var logic exclusive_cache_enable,
  output var logic coherency_participation,
  output var logic maintenance_broadcast_enable,
  output var logic inner_shared_noncacheable,
  output var logic maint_broadcast_send_en,
  output var logic maint_broadcast_accept_en,
  output var logic coherent_request_en,
  output var logic l2_fill_on_evict
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MULTI_CORE != 0 && MULTI_CORE != 1) begin : g_chk_mc
    $error("MULTI_CORE must be 0 or 1");
  end
  if (PARITY_PRESENT != 0 && PARITY_PRESENT != 1) begin : g_chk_par
    $error("PARITY_PRESENT must be 0 or 1");
  end

  localparam logic HAS_MP = (MULTI_CORE != 0);
  localparam logic HAS_PARITY = (PARITY_PRESENT != 0);

  // ----------------------------------------------------------------
  // lock pin synchroniser
  // ----------------------------------------------------------------
  logic lock_sync;

  sacr_pin_sync u_lock_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(secure_config_write_lock),
    .level_out(lock_sync)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [NUM_BANKS-1:0] xlat_q;
  logic [NUM_BANKS-1:0] align_q;
  logic rr_q;
  logic parity_q;
  logic oneway_q;
  logic exclusive_cache_enable_q;
  logic smp_q;
  logic fw_q;
  logic done_q;
  logic undef_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire tgt_sys = (acc_target == TGT_SYSTEM);
  wire tgt_aux = (acc_target == TGT_AUX);
  // user mode traps on system control
  wire undef_user_sys = acc_valid & acc_user & tgt_sys;
  // user mode also traps on the auxiliary register
  wire undef_user_aux = acc_valid & acc_user & tgt_aux;
  wire undef_lock = acc_valid & acc_write & acc_secure & ~acc_user & lock_sync;
  wire undef_d = undef_user_sys | undef_user_aux | undef_lock;
  wire acc_ok = acc_valid & ~undef_d;
  wire wr_ok = acc_ok & acc_write;
  wire sys_wr = wr_ok & tgt_sys;
  // secure writes reach every aux field
  wire aux_wr_full = wr_ok & tgt_aux & acc_secure;
  // non-secure writes reach only participation, and only when permitted
  wire aux_wr_smp = wr_ok & tgt_aux & ~acc_secure & nonsecure_coherency_write_permit;
  // secure-modify-only fields take secure writes alone
  wire rr_wr = sys_wr & acc_secure;

  // ----------------------------------------------------------------
  // banked system control fields, one copy per security state
  // ----------------------------------------------------------------
  genvar bank;
  for (bank = 0; bank < NUM_BANKS; bank++) begin : g_bank
    wire bank_hit = sys_wr & (acc_secure == (bank == BANK_SECURE));
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        xlat_q[bank] <= RST_XLAT;
        align_q[bank] <= RST_ALIGN;
      end else if (bank_hit) begin
        xlat_q[bank] <= acc_wdata[SYS_XLAT_BIT];
        align_q[bank] <= acc_wdata[SYS_ALIGN_BIT];
      end
    end
  end

  // replacement policy bit held only as the secure copy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rr_q <= RST_RR;
    end else if (rr_wr) begin
      rr_q <= acc_wdata[SYS_RR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // auxiliary control fields, one copy shared by both states
  // ----------------------------------------------------------------
  // parity enable sticks at zero without parity hardware
  wire parity_d = aux_wr_full ? (HAS_PARITY & acc_wdata[AUX_PARITY_BIT]) : parity_q;
  // broadcast enable sticks at zero on a single core
  wire fw_d = aux_wr_full ? (HAS_MP & acc_wdata[AUX_FW_BIT]) : fw_q;
  // participation written by secure or permitted non-secure code
  wire smp_d = (aux_wr_full | aux_wr_smp) ? acc_wdata[AUX_SMP_BIT] : smp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parity_q <= RST_PARITY;
      oneway_q <= RST_ONEWAY;
      exclusive_cache_enable_q <= RST_EXCLUSIVE_CACHE_ENABLE;
      smp_q <= RST_SMP;
      fw_q <= RST_FW;
    end else begin
      parity_q <= parity_d;
      smp_q <= smp_d;
      fw_q <= fw_d;
      if (aux_wr_full) begin
        oneway_q <= acc_wdata[AUX_ONEWAY_BIT];
        exclusive_cache_enable_q <= acc_wdata[AUX_EXCLUSIVE_CACHE_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data assembly
  // ----------------------------------------------------------------
  wire rd_bank_xlat = acc_secure ? xlat_q[BANK_SECURE] : xlat_q[BANK_NONSECURE];
  wire rd_bank_align = acc_secure ? align_q[BANK_SECURE] : align_q[BANK_NONSECURE];
  // secure copy read by all, fixed bits unchanged by writes
  wire [31:0] sys_rdata = SYS_FIXED_ONES
                        | (32'(rr_q) << SYS_RR_BIT)
                        | (32'(rd_bank_align) << SYS_ALIGN_BIT)
                        | (32'(rd_bank_xlat) << SYS_XLAT_BIT);
  // reserved aux bits read as zero
  wire [31:0] aux_rdata = (32'(parity_q) << AUX_PARITY_BIT)
                        | (32'(oneway_q) << AUX_ONEWAY_BIT)
                        | (32'(exclusive_cache_enable_q) << AUX_EXCLUSIVE_CACHE_ENABLE_BIT)
                        | (32'(smp_q) << AUX_SMP_BIT)
                        | (32'(fw_q) << AUX_FW_BIT);
  wire rd_ok = acc_ok & ~acc_write;
  wire [31:0] rdata_d = rd_ok ? (tgt_sys ? sys_rdata : aux_rdata) : 32'h0000_0000;

  // answer one cycle after each access is taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'h0;
      undef_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_q <= acc_valid;
      undef_q <= undef_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // policy controls
  // ----------------------------------------------------------------
  sacr_coh_policy #(
    .MULTI_CORE(MULTI_CORE)
  ) u_policy (
    .clk_sys(clk_sys),
    .rst(rst),
    .smp_en(smp_q),
    .fw_en(fw_q),
    .exclusive_cache_enable_en(exclusive_cache_enable_q),
    .evict_valid(evict_valid),
    .evict_wb_cacheable(evict_wb_cacheable),
    .evict_l1_allocated(evict_l1_allocated),
    .inner_shared_noncacheable(inner_shared_noncacheable),
    .maint_broadcast_send_en(maint_broadcast_send_en),
    .maint_broadcast_accept_en(maint_broadcast_accept_en),
    .coherent_request_en(coherent_request_en),
    .l2_fill_on_evict(l2_fill_on_evict)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // running core uses the bank of its current security state
  assign translation_en = core_secure ? xlat_q[BANK_SECURE] : xlat_q[BANK_NONSECURE];
  assign align_check_en = core_secure ? align_q[BANK_SECURE] : align_q[BANK_NONSECURE];
  assign round_robin_en = rr_q;
  assign parity_check_en = parity_q;
  assign single_way_alloc_en = oneway_q;
  assign exclusive_cache_enable = exclusive_cache_enable_q;
  assign coherency_participation = smp_q;
  assign maintenance_broadcast_enable = fw_q;
  assign acc_done = done_q;
  assign acc_undef = undef_q;
  assign acc_rdata = rdata_q;

endmodule
`default_nettype wire

// ### tb/sacr_ctrl_regs_checker.sv
// concurrent checks on the ports of the control register bank
`timescale 1ns/1ps
`default_nettype none
module sacr_ctrl_regs_checker #(
  parameter int MULTI_CORE = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_target,
  input wire logic acc_user,
  input wire logic acc_secure,
  input wire logic secure_config_write_lock,
  input wire logic nonsecure_coherency_write_permit,
  input wire logic evict_valid,
  input wire logic evict_wb_cacheable,
  input wire logic evict_l1_allocated,
  input wire logic acc_done,
  input wire logic acc_undef,
  input wire logic [31:0] acc_rdata,
  input wire logic translation_en,
  input wire logic align_check_en,
  input wire logic round_robin_en,
  input wire logic parity_check_en,
  input wire logic single_way_alloc_en,
  input wire logic exclusive_cache_enable,
  input wire logic coherency_participation,
  input wire logic maintenance_broadcast_enable,
  input wire logic inner_shared_noncacheable,
  input wire logic maint_broadcast_send_en,
  input wire logic maint_broadcast_accept_en,
  input wire logic coherent_request_en,
  input wire logic l2_fill_on_evict
);
  // ----------------------------------------------------------------
  // helpers and defaults
  // ----------------------------------------------------------------
  localparam bit multi_on = (MULTI_CORE != 0);
  // aux field levels gathered for stability checks
  wire logic [4:0] aux_bits = {parity_check_en, single_way_alloc_en, exclusive_cache_enable,
    coherency_participation, maintenance_broadcast_enable};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  user_trap_a: assert property (
    acc_valid && acc_user |=> acc_done && acc_undef && acc_rdata == 32'h0
  ) else $error("user mode access not trapped");
  priv_read_a: assert property (
    acc_valid && !acc_user && !acc_write |=> acc_done && !acc_undef
  ) else $error("privileged read not served");
  lock_trap_a: assert property (
    secure_config_write_lock [*6] ##0 (acc_valid && acc_write && acc_secure && !acc_user)
      |=> acc_undef
  ) else $error("locked secure write not trapped");
  reset_clear_a: assert property (
    $fell(rst) |-> !translation_en && !align_check_en && aux_bits == 5'h0
  ) else $error("field not clear after reset");
  rr_secure_a: assert property (
    acc_valid && acc_write && !acc_target && !acc_secure |=> $stable(round_robin_en)
  ) else $error("nonsecure write changed secure field");
  ns_ro_a: assert property (
    acc_valid && acc_write && acc_target && !acc_secure && !nonsecure_coherency_write_permit
      |=> $stable(aux_bits)
  ) else $error("aux changed by nonsecure write");
  ns_permit_a: assert property (
    acc_valid && acc_write && acc_target && !acc_secure |=> $stable({aux_bits[4:2], aux_bits[0]})
  ) else $error("nonsecure write changed protected aux field");
  noncache_a: assert property (
    inner_shared_noncacheable == !coherency_participation
  ) else $error("inner shareable cacheability wrong");
  bcast_send_a: assert property (
    maint_broadcast_send_en == (multi_on && coherency_participation && maintenance_broadcast_enable)
  ) else $error("broadcast send enable wrong");
  bcast_accept_a: assert property (
    maint_broadcast_accept_en == (multi_on && coherency_participation && maintenance_broadcast_enable)
  ) else $error("broadcast accept enable wrong");
  coh_req_a: assert property (
    coherent_request_en == (multi_on && coherency_participation)
  ) else $error("coherent request enable wrong");
  evict_fill_a: assert property (
    1'b1 |=> l2_fill_on_evict == $past(evict_valid && evict_wb_cacheable && evict_l1_allocated
      && exclusive_cache_enable)
  ) else $error("second level fill wrong");
  cover property (acc_valid && acc_user);
  cover property (acc_undef && !$past(acc_user));
  cover property (l2_fill_on_evict);
endmodule
bind sacr_ctrl_regs sacr_ctrl_regs_checker #(.MULTI_CORE(MULTI_CORE))
  u_sacr_ctrl_regs_checker (.*);
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // signals and access table
  // ----------------------------------------------------------------
  // ctl is {write, target, user, secure, permit}
  typedef struct packed {logic [4:0] ctl; logic [31:0] wd; logic ux; logic [31:0] rx;} sacr_row_t;
  logic clk_sys = 1'h0, rst = 1'h1, acc_valid = 1'h0, acc_write = 1'h0, acc_target = 1'h0;
  logic acc_user = 1'h0, acc_secure = 1'h0, core_secure = 1'h1, secure_config_write_lock = 1'h0;
  logic nonsecure_coherency_write_permit = 1'h0, evict_valid = 1'h0, evict_wb_cacheable = 1'h0;
  logic evict_l1_allocated = 1'h0, acc_done, acc_undef, translation_en, align_check_en;
  logic [31:0] acc_wdata = 32'h0, acc_rdata;
  logic round_robin_en, parity_check_en, single_way_alloc_en, exclusive_cache_enable;
  logic coherency_participation, maintenance_broadcast_enable, inner_shared_noncacheable;
  logic maint_broadcast_send_en, maint_broadcast_accept_en, coherent_request_en, l2_fill_on_evict;
  int err_count = 0, check_count = 0;
  sacr_row_t rows [24] = '{
    '{5'h02, 32'h0, 1'h0, 32'h00C5_0078}, '{5'h12, 32'hFFFF_FFFF, 1'h0, 32'h0},
    '{5'h02, 32'h0, 1'h0, 32'h00C5_407B}, '{5'h00, 32'h0, 1'h0, 32'h00C5_4078},
    '{5'h10, 32'h3, 1'h0, 32'h0}, '{5'h00, 32'h0, 1'h0, 32'h00C5_407B},
    '{5'h12, 32'h0, 1'h0, 32'h0}, '{5'h00, 32'h0, 1'h0, 32'h00C5_007B},
    '{5'h10, 32'h4000, 1'h0, 32'h0}, '{5'h02, 32'h0, 1'h0, 32'h00C5_0078},
    '{5'h06, 32'h0, 1'h1, 32'h0}, '{5'h14, 32'h3, 1'h1, 32'h0},
    '{5'h00, 32'h0, 1'h0, 32'h00C5_0078}, '{5'h1A, 32'hFFFF_FFFF, 1'h0, 32'h0},
    '{5'h08, 32'h0, 1'h0, 32'h3C1}, '{5'h18, 32'h0, 1'h0, 32'h0},
    '{5'h0A, 32'h0, 1'h0, 32'h3C1}, '{5'h19, 32'h0, 1'h0, 32'h0},
    '{5'h0A, 32'h0, 1'h0, 32'h381}, '{5'h19, 32'hFFFF_FFFF, 1'h0, 32'h0},
    '{5'h0A, 32'h0, 1'h0, 32'h3C1}, '{5'h0E, 32'h0, 1'h1, 32'h0},
    '{5'h1A, 32'h0, 1'h0, 32'h0}, '{5'h0A, 32'h0, 1'h0, 32'h0}};

  // clock generation
  always #10 clk_sys = ~clk_sys;

  sacr_ctrl_regs #(.MULTI_CORE(1), .PARITY_PRESENT(1)) u_sacr_ctrl_regs (.*);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one access, answer checked in the cycle it stands
  task automatic acc(input sacr_row_t r);
    cyc(1);
    {acc_write, acc_target, acc_user, acc_secure, nonsecure_coherency_write_permit} = r.ctl;
    acc_wdata = r.wd;
    acc_valid = 1'h1;
    cyc(1);
    acc_valid = 1'h0;
    chk(acc_done === 1'h1 && acc_undef === r.ux && acc_rdata === r.rx, "access answer");
  endtask

  task automatic aux_wr(input logic [31:0] wd);
    acc('{5'h1A, wd, 1'h0, 32'h0});
  endtask

  task automatic chk_rst();
    chk({translation_en, align_check_en, round_robin_en, parity_check_en, single_way_alloc_en,
      exclusive_cache_enable, coherency_participation, maintenance_broadcast_enable,
      coherent_request_en, inner_shared_noncacheable} === 10'h001, "reset levels");
  endtask

  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  // main sequence: table first, then the awkward cases
  initial begin
    cyc(20);
    rst = 1'h0;
    chk_rst();
    foreach (rows[i]) acc(rows[i]);
    acc('{5'h12, 32'h3, 1'h0, 32'h0});
    acc('{5'h10, 32'h2, 1'h0, 32'h0});
    chk(translation_en === 1'h1 && align_check_en === 1'h1, "secure bank levels");
    core_secure = 1'h0;
    #1;
    chk(translation_en === 1'h0 && align_check_en === 1'h1, "nonsecure levels");
    secure_config_write_lock = 1'h1;
    cyc(6);
    acc('{5'h12, 32'h0, 1'h1, 32'h0});
    acc('{5'h1A, 32'hFFFF_FFFF, 1'h1, 32'h0});
    acc('{5'h0A, 32'h0, 1'h0, 32'h0});
    acc('{5'h02, 32'h0, 1'h0, 32'h00C5_007B});
    secure_config_write_lock = 1'h0;
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      aux_wr({25'h0, i[1], 5'h0, i[0]});
      chk(inner_shared_noncacheable === !i[1], "cacheability level");
      chk(coherent_request_en === i[1], "coherent request level");
      chk(maint_broadcast_send_en === (i[1] & i[0]), "send level");
      chk(maint_broadcast_accept_en === (i[1] & i[0]), "accept level");
    end
    for (int e = 1; e >= 0; e--) begin
      aux_wr({24'h0, e[0], 7'h0});
      for (int i = 0; i < 8; i++) begin
        {evict_valid, evict_wb_cacheable, evict_l1_allocated} = i[2:0];
        cyc(1);
        {evict_valid, evict_wb_cacheable, evict_l1_allocated} = 3'h0;
        chk(l2_fill_on_evict === (e == 1 && i == 7), "eviction fill");
      end
    end
    aux_wr(32'hFFFF_FFFF);
    chk({parity_check_en, single_way_alloc_en, exclusive_cache_enable, coherency_participation,
      maintenance_broadcast_enable} === 5'h1F, "aux field levels");
    acc('{5'h12, 32'hFFFF_FFFF, 1'h0, 32'h0});
    chk(round_robin_en === 1'h1, "replacement level");
    rst = 1'h1;
    cyc(4);
    rst = 1'h0;
    chk_rst();
    acc('{5'h0A, 32'h0, 1'h0, 32'h0});
    acc('{5'h02, 32'h0, 1'h0, 32'h00C5_0078});
    end_sim();
  end

  // watchdog against a hang
  initial begin
    cyc(5000);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
